// >>> obc_params.svh
// Constants for the option byte configuration loader.
`ifndef OBC_PARAMS_SVH
`define OBC_PARAMS_SVH

// ****************************************
// Register map
// ****************************************
`define OBC_REG_CTRL 8'h00
`define OBC_REG_STATUS 8'h04
`define OBC_CTRL_RELOAD 0
`define OBC_CTRL_CLR_ERASED 1
`define OBC_STAT_LOADED 0
`define OBC_STAT_PROG_MODE 1
`define OBC_STAT_ERASED 2
`define OBC_STAT_PENDING 3
`define OBC_WORD_ZERO 32'h0000_0000

// ****************************************
// Option byte values and addresses
// ****************************************
`define OBC_BLANK_BYTE 8'hFF
`define OBC_ERASED_BYTE 8'h00
`define OBC_ADDR_BYTE0 1'b0
`define OBC_ADDR_BYTE1 1'b1

// ****************************************
// Option byte 0 fields
// ****************************************
`define OBC_B0_PKG 1
`define OBC_B0_PROTECT 0

// ****************************************
// Option byte 1 fields
// ****************************************
`define OBC_B1_SUPERVISOR_OFF 7
`define OBC_B1_SRC_HI 6
`define OBC_B1_SRC_LO 4
`define OBC_B1_BOR_HI 3
`define OBC_B1_BOR_LO 2
`define OBC_B1_HALT 1
`define OBC_B1_SOFT_WATCHDOG 0

// ****************************************
// Field encodings
// ****************************************
`define OBC_SRC_CODE_EXT 3'b111
`define OBC_SRC_CODE_IRC 3'b110
`define OBC_SRC_CODE_ERC 3'b10?
`define OBC_SRC_CODE_LOW_DRIVE 3'b011
`define OBC_SRC_CODE_MID_DRIVE 3'b010
`define OBC_SRC_CODE_MID_SPEED 3'b001
`define OBC_SRC_CODE_FAST 3'b000
`define OBC_BOR_OFF 2'b11
`define OBC_BOR_HIGH 2'b10
`define OBC_BOR_MID 2'b01
`define OBC_BOR_LOW 2'b00

`endif

// >>> obc_pkg.sv
// Types shared by the option byte configuration loader.
package obc_pkg;

  typedef enum logic [2:0] {
    OBC_SRC_EXT_CLOCK,
    OBC_SRC_INTERNAL_RC,
    OBC_SRC_EXTERNAL_RC,
    OBC_SRC_LOW_DRIVE_RESONATOR,
    OBC_SRC_MID_DRIVE_RESONATOR,
    OBC_SRC_MID_SPEED_RESONATOR,
    OBC_SRC_FAST_RESONATOR
  } obc_clk_src_t;

  typedef enum logic [1:0] {
    OBC_BOR_DET_OFF,
    OBC_BOR_DET_HIGH,
    OBC_BOR_DET_MID,
    OBC_BOR_DET_LOW
  } obc_bor_t;

  typedef struct packed {
    logic pkg_wide;
    logic full_readout_protect;
    logic clock_supervisor_off;
    obc_clk_src_t clock_source_select;
    obc_bor_t brownout_level_select;
    logic halt_reset_on_watchdog;
    logic soft_watchdog_select;
  } obc_cfg_t;

  typedef struct packed {
    logic req;
    logic we;
    logic addr;
    logic [7:0] wdata;
  } obc_prog_req_t;

  typedef struct packed {
    logic [7:0] byte0;
    logic [7:0] byte1;
    logic [7:0] rdata;
    logic ack;
    logic err;
    logic erase;
  } obc_cells_st_t;

  typedef struct packed {
    obc_cfg_t cfg;
    logic loaded;
    logic load_pend;
    logic erased;
    logic [31:0] prdata;
    logic slverr;
  } obc_top_st_t;

endpackage : obc_pkg

// >>> obc_option_cells.sv
// Option byte storage with the programming-mode access port.
`timescale 1ns/1ns
`include "obc_params.svh"

module obc_option_cells #(
  parameter bit MASK_CODED = 1'b0,
  parameter logic [7:0] MASK_BYTE0 = `OBC_BLANK_BYTE,
  parameter logic [7:0] MASK_BYTE1 = `OBC_BLANK_BYTE
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Programming port
  input wire logic prog_mode_i,
  input wire obc_pkg::obc_prog_req_t prog_req_i,
  output logic [7:0] prog_rdata_o,
  output logic prog_ack_o,
  output logic prog_err_o,
  // Stored bytes and erase event
  output logic [7:0] byte0_o,
  output logic [7:0] byte1_o,
  output logic erase_o
);

  obc_pkg::obc_cells_st_t s_r;
  obc_pkg::obc_cells_st_t s_nxt;
  logic [7:0] eff0;
  logic [7:0] eff1;

  // Mask parts take the bytes from the factory code, never from cells.
  assign eff0 = MASK_CODED ? MASK_BYTE0 : s_r.byte0;
  assign eff1 = MASK_CODED ? MASK_BYTE1 : s_r.byte1;

  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.err = 1'b0;
    s_nxt.erase = 1'b0;
    if (prog_req_i.req) begin
      if (!prog_mode_i || (prog_req_i.we && MASK_CODED)) begin
        s_nxt.err = 1'b1;
      end else begin
        s_nxt.ack = 1'b1;
        if (!prog_req_i.we) begin
          s_nxt.rdata = (prog_req_i.addr == `OBC_ADDR_BYTE1) ? eff1 : eff0;
        end else if (prog_req_i.addr == `OBC_ADDR_BYTE1) begin
          s_nxt.byte1 = prog_req_i.wdata;
        end else if (s_r.byte0[`OBC_B0_PROTECT] &&
                     !prog_req_i.wdata[`OBC_B0_PROTECT]) begin
          // Dropping protection wipes the option bytes with the array.
          s_nxt.byte0 = `OBC_ERASED_BYTE;
          s_nxt.byte1 = `OBC_ERASED_BYTE;
          s_nxt.erase = 1'b1;
        end else begin
          s_nxt.byte0 = prog_req_i.wdata;
        end
      end
    end
  end

  // Flip-flops stand in for the nonvolatile cells; the reset value is
  // the blank content of a part as shipped.
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '{byte0: `OBC_BLANK_BYTE, byte1: `OBC_BLANK_BYTE,
               rdata: `OBC_ERASED_BYTE, ack: 1'b0, err: 1'b0,
               erase: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign byte0_o = eff0;
  assign byte1_o = eff1;
  assign prog_rdata_o = s_r.rdata;
  assign prog_ack_o = s_r.ack;
  assign prog_err_o = s_r.err;
  assign erase_o = s_r.erase;

endmodule : obc_option_cells

// >>> obc_option_decode.sv
// Combinational decode of the two option bytes into settings.
`timescale 1ns/1ns
`include "obc_params.svh"

module obc_option_decode (
  // Raw option bytes
  input wire logic [7:0] byte0_i,
  input wire logic [7:0] byte1_i,
  // Decoded settings
  output obc_pkg::obc_cfg_t cfg_o
);

  logic [2:0] src_code;
  logic [1:0] bor;

  assign src_code = byte1_i[`OBC_B1_SRC_HI:`OBC_B1_SRC_LO];
  assign bor = byte1_i[`OBC_B1_BOR_HI:`OBC_B1_BOR_LO];

  always_comb begin
    // Bits 7 to 2 of byte 0 are never looked at.
    cfg_o.pkg_wide = byte0_i[`OBC_B0_PKG];
    cfg_o.full_readout_protect = byte0_i[`OBC_B0_PROTECT];
    cfg_o.clock_supervisor_off = byte1_i[`OBC_B1_SUPERVISOR_OFF];
    cfg_o.halt_reset_on_watchdog = byte1_i[`OBC_B1_HALT];
    cfg_o.soft_watchdog_select = byte1_i[`OBC_B1_SOFT_WATCHDOG];
    casez (src_code)
      `OBC_SRC_CODE_EXT: begin
        cfg_o.clock_source_select = obc_pkg::OBC_SRC_EXT_CLOCK;
      end
      `OBC_SRC_CODE_IRC: begin
        cfg_o.clock_source_select = obc_pkg::OBC_SRC_INTERNAL_RC;
      end
      `OBC_SRC_CODE_ERC: begin
        cfg_o.clock_source_select = obc_pkg::OBC_SRC_EXTERNAL_RC;
      end
      `OBC_SRC_CODE_LOW_DRIVE: begin
        cfg_o.clock_source_select = obc_pkg::OBC_SRC_LOW_DRIVE_RESONATOR;
      end
      `OBC_SRC_CODE_MID_DRIVE: begin
        cfg_o.clock_source_select = obc_pkg::OBC_SRC_MID_DRIVE_RESONATOR;
      end
      `OBC_SRC_CODE_MID_SPEED: begin
        cfg_o.clock_source_select = obc_pkg::OBC_SRC_MID_SPEED_RESONATOR;
      end
      default: cfg_o.clock_source_select = obc_pkg::OBC_SRC_FAST_RESONATOR;
    endcase
    case (bor)
      `OBC_BOR_OFF: cfg_o.brownout_level_select = obc_pkg::OBC_BOR_DET_OFF;
      `OBC_BOR_HIGH: cfg_o.brownout_level_select = obc_pkg::OBC_BOR_DET_HIGH;
      `OBC_BOR_MID: cfg_o.brownout_level_select = obc_pkg::OBC_BOR_DET_MID;
      default: cfg_o.brownout_level_select = obc_pkg::OBC_BOR_DET_LOW;
    endcase
  end

endmodule : obc_option_decode

// >>> obc_option_loader.sv
// Top of the option byte configuration loader with its APB slave.
`timescale 1ns/1ns
`include "obc_params.svh"

// ****************************************
// Option byte configuration loader
// ****************************************
// Functional notes
// - The option bytes have no bus address, so software can never read or write them.
// - The option bytes are reachable only in programming mode, which the programmer enters first.
// - Blank programmable parts hold all-ones in both option bytes.
// - Mask-coded parts take the option values from fixed factory code that cannot be changed.
// - Byte 0 bit 1 selects the package: 0 for the 42/44-pin and 1 for the 56/64-pin arrangement.
// - Byte 0 bit 0 set blocks external read-out of program memory, cleared leaves it readable.
// - Clearing the read-out protection bit erases the program memory and option bytes to zero.
// - The read-out protection never blocks reading of the data nonvolatile memory.
// - Byte 1 bit 7 at 0 enables the clock supervisor and at 1 disables it.
// - Byte 1 bits 6 to 4 select the source that drives the main oscillator.
// - The source field decodes 111 external clock, 110 internal RC, 10x external RC, 011 low drive, 010 mid drive, 001 mid speed, 000 fast resonator.
// - Byte 1 bits 3 and 2 enable the brownout detector and select its threshold.
// - The brownout field decodes 11 off, 10 highest, 01 medium and 00 lowest threshold.
// - Byte 1 bit 1 at 1 makes halt with the watchdog running cause a reset, at 0 not.
// - Byte 1 bit 0 at 0 keeps the watchdog always on, at 1 leaves enabling to software.
module obc_option_loader #(
  parameter bit MASK_CODED = 1'b0,
  parameter logic [7:0] MASK_BYTE0 = `OBC_BLANK_BYTE,
  parameter logic [7:0] MASK_BYTE1 = `OBC_BLANK_BYTE
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Programming port
  input wire logic prog_mode_i,
  input wire obc_pkg::obc_prog_req_t prog_req_i,
  output logic [7:0] prog_rdata_o,
  output logic prog_ack_o,
  output logic prog_err_o,
  // Decoded configuration
  output obc_pkg::obc_cfg_t cfg_o,
  output logic cfg_valid_o,
  // Memory access controls
  output logic prog_mem_read_allow_o,
  output logic data_nvm_read_allow_o,
  output logic prog_mem_erase_o
);

  // ****************************************
  // Option byte storage and decode
  // ****************************************
  logic [7:0] opt_byte0;
  logic [7:0] opt_byte1;
  logic erase_evt;
  obc_pkg::obc_cfg_t cfg_dec;

  // The only way to the option bytes is this port, gated by the
  // programming mode inside the storage.
  obc_option_cells #(
    .MASK_CODED(MASK_CODED),
    .MASK_BYTE0(MASK_BYTE0),
    .MASK_BYTE1(MASK_BYTE1)
  ) u_cells (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .prog_mode_i(prog_mode_i),
    .prog_req_i(prog_req_i),
    .prog_rdata_o(prog_rdata_o),
    .prog_ack_o(prog_ack_o),
    .prog_err_o(prog_err_o),
    .byte0_o(opt_byte0),
    .byte1_o(opt_byte1),
    .erase_o(erase_evt)
  );

  obc_option_decode u_decode (
    .byte0_i(opt_byte0),
    .byte1_i(opt_byte1),
    .cfg_o(cfg_dec)
  );

  // ****************************************
  // APB access decode
  // ****************************************
  logic setup_ph;
  logic access_ph;
  logic hit_ctrl;
  logic hit_status;
  logic wr_ctrl;
  logic reload_req;
  logic clr_erased;

  assign setup_ph = psel_i && !penable_i;
  assign access_ph = psel_i && penable_i;
  assign hit_ctrl = (paddr_i == `OBC_REG_CTRL);
  assign hit_status = (paddr_i == `OBC_REG_STATUS);
  // Byte lane 0 carries every control bit.
  assign wr_ctrl = access_ph && pwrite_i && hit_ctrl && pstrb_i[0];
  assign reload_req = wr_ctrl && pwdata_i[`OBC_CTRL_RELOAD];
  assign clr_erased = wr_ctrl && pwdata_i[`OBC_CTRL_CLR_ERASED];

  // ****************************************
  // State update
  // ****************************************
  obc_pkg::obc_top_st_t s_r;
  obc_pkg::obc_top_st_t s_nxt;
  logic [31:0] status_word;

  // Status shows only loader state and the programming mode input; the option
  // values themselves never appear on the bus.
  always_comb begin
    status_word = `OBC_WORD_ZERO;
    status_word[`OBC_STAT_LOADED] = s_r.loaded;
    status_word[`OBC_STAT_PROG_MODE] = prog_mode_i;
    status_word[`OBC_STAT_ERASED] = s_r.erased;
    status_word[`OBC_STAT_PENDING] = s_r.load_pend;
  end

  always_comb begin
    s_nxt = s_r;
    // Settings are taken over one cycle after a request, so that all
    // consumers see a whole new set at once and never a mix.
    if (s_r.load_pend) begin
      s_nxt.cfg = cfg_dec;
      s_nxt.loaded = 1'b1;
      s_nxt.load_pend = 1'b0;
    end
    if (reload_req) begin
      s_nxt.load_pend = 1'b1;
    end
    // An erase drops protection at once, so the settings follow it.
    if (erase_evt) begin
      s_nxt.load_pend = 1'b1;
    end
    // A fresh erase wins over a clear in the same cycle.
    if (clr_erased) begin
      s_nxt.erased = 1'b0;
    end
    if (erase_evt) begin
      s_nxt.erased = 1'b1;
    end
    // Read data and error are fixed in the setup cycle, ready in access.
    if (setup_ph) begin
      s_nxt.slverr = !(hit_ctrl || hit_status);
      if (!pwrite_i && hit_status) begin
        s_nxt.prdata = status_word;
      end else begin
        s_nxt.prdata = `OBC_WORD_ZERO;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '{cfg: '0, loaded: 1'b0, load_pend: 1'b1, erased: 1'b0,
               prdata: `OBC_WORD_ZERO, slverr: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata_o = s_r.prdata;
  assign pready_o = access_ph;
  assign pslverr_o = access_ph && s_r.slverr;
  assign cfg_o = s_r.cfg;
  assign cfg_valid_o = s_r.loaded;
  // Until the first load the program memory stays closed to the outside.
  assign prog_mem_read_allow_o =
    s_r.loaded && !s_r.cfg.full_readout_protect;
  assign data_nvm_read_allow_o = 1'b1;
  assign prog_mem_erase_o = erase_evt;

endmodule : obc_option_loader

// >>> obc_prog_tool.sv
// Model of the external programming tool on the option byte port.
`timescale 1ns/1ns
module obc_prog_tool (
  // Clock
  input wire logic clk_sys_i,
  // Programming port
  output obc_pkg::obc_prog_req_t prog_req_o,
  output logic prog_mode_o,
  input wire logic [7:0] prog_rdata_i,
  input wire logic prog_ack_i,
  input wire logic prog_err_i
);
  initial begin
    prog_req_o = '0;
    prog_mode_o = 1'b0;
  end
  task automatic set_mode(input logic on);
    @(posedge clk_sys_i);
    prog_mode_o <= on;
  endtask : set_mode
  // The request is a single-cycle pulse; the byte is scrambled once taken.
  task automatic access(input logic we, input logic addr,
                        input logic [7:0] wd, output logic [7:0] rd,
                        output logic ok);
    @(posedge clk_sys_i);
    prog_req_o <= '{1'b1, we, addr, addr ? wd : wd | 8'hFC};
    @(posedge clk_sys_i);
    prog_req_o.req <= 1'b0;
    prog_req_o.wdata <= ~prog_req_o.wdata;
    // Only the bench watchdog ends a wait for an answer that never comes.
    while (!(prog_ack_i || prog_err_i)) begin
      @(posedge clk_sys_i);
    end
    rd = prog_rdata_i;
    ok = prog_ack_i;
  endtask : access
endmodule : obc_prog_tool

// >>> obc_loader_sva.sv
// Port assertions for the option byte configuration loader.
`timescale 1ns/1ns
module obc_loader_sva (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Bus and programming port
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic prog_mode_i,
  input wire obc_pkg::obc_prog_req_t prog_req_i,
  input wire logic prog_ack_o,
  input wire logic prog_err_o,
  // Settings and access controls
  input wire obc_pkg::obc_cfg_t cfg_o,
  input wire logic cfg_valid_o,
  input wire logic prog_mem_read_allow_o,
  input wire logic data_nvm_read_allow_o,
  input wire logic prog_mem_erase_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_unmapped_refused: assert property (
    psel_i && penable_i && paddr_i != 8'h00 && paddr_i != 8'h04 |-> pslverr_o)
    else $error("unmapped access not refused");
  a_mode_refused: assert property (
    prog_req_i.req && !prog_mode_i |=> prog_err_o && !prog_ack_o)
    else $error("request outside programming mode accepted");
  a_read_answered: assert property (
    prog_req_i.req && prog_mode_i && !prog_req_i.we |=> prog_ack_o)
    else $error("read in programming mode not acknowledged");
  a_one_answer: assert property (
    prog_req_i.req |=> prog_ack_o != prog_err_o)
    else $error("request without exactly one answer");
  a_erase_cause: assert property (
    prog_mem_erase_o |-> $past(prog_req_i.req && prog_mode_i &&
      prog_req_i.we && !prog_req_i.addr && !prog_req_i.wdata[0]))
    else $error("erase without protection clear");
  a_erase_zeroes: assert property (
    prog_mem_erase_o |-> ##2 cfg_o == 10'b00_0110_1100)
    else $error("settings not from zero bytes after erase");
  a_nvm_open: assert property (data_nvm_read_allow_o)
    else $error("data memory read blocked");
  a_read_gate: assert property (
    cfg_valid_o |-> prog_mem_read_allow_o == !cfg_o.full_readout_protect)
    else $error("read gate disagrees with protection");
  a_gate_early: assert property (
    !cfg_valid_o |-> !prog_mem_read_allow_o)
    else $error("read allowed before load");
  c_erase: cover property (prog_mem_erase_o);
  c_refused: cover property (prog_err_o);
  c_slverr: cover property (psel_i && penable_i && pslverr_o);
endmodule : obc_loader_sva
bind obc_option_loader obc_loader_sva u_sva (.clk_sys_i, .reset_n_i,
  .psel_i, .penable_i, .paddr_i, .pslverr_o, .prog_mode_i, .prog_req_i,
  .prog_ack_o, .prog_err_o, .cfg_o, .cfg_valid_o, .prog_mem_read_allow_o,
  .data_nvm_read_allow_o, .prog_mem_erase_o);

// >>> testbench.sv
// Self-checking testbench for the option byte configuration loader.
`timescale 1ns/1ns
module testbench;
  logic clk_sys_i, reset_n_i, psel_i, penable_i, pwrite_i, pready_o;
  logic pslverr_o, prog_mode_i, prog_ack_o, prog_err_o, cfg_valid_o;
  logic prog_mem_read_allow_o, data_nvm_read_allow_o, prog_mem_erase_o;
  logic [7:0] paddr_i, prog_rdata_o, rb;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [3:0] pstrb_i;
  logic ok, se;
  obc_pkg::obc_prog_req_t prog_req_i;
  obc_pkg::obc_cfg_t cfg_o;
  obc_pkg::obc_cfg_t m_cfg;
  logic [7:0] m_rdata;
  logic m_err;
  int num_errors, checks;
  // Byte 0, byte 1, then settings: pkg, protect, css, src, bor, halt, soft.
  logic [25:0] rows [8] = '{
    {8'hFF, 8'hFF, 10'b11_1000_0011}, {8'hFD, 8'h68, 10'b01_0001_0100},
    {8'hFF, 8'hD6, 10'b11_1010_1010}, {8'hFD, 8'h41, 10'b01_0010_1101},
    {8'hFF, 8'hBD, 10'b11_1011_0001}, {8'hFD, 8'h2B, 10'b01_0100_0111},
    {8'hFF, 8'h14, 10'b11_0101_1000}, {8'hFD, 8'h82, 10'b01_1110_1110}};
  obc_option_loader dut (.clk_sys_i, .reset_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
    .pslverr_o, .prog_mode_i, .prog_req_i, .prog_rdata_o, .prog_ack_o,
    .prog_err_o, .cfg_o, .cfg_valid_o, .prog_mem_read_allow_o,
    .data_nvm_read_allow_o, .prog_mem_erase_o);
  obc_prog_tool tool (.clk_sys_i, .prog_req_o(prog_req_i),
    .prog_mode_o(prog_mode_i), .prog_rdata_i(prog_rdata_o),
    .prog_ack_i(prog_ack_o), .prog_err_i(prog_err_o));
  // A mask part beside the programmable one; unused bits are all ones.
  obc_option_loader #(.MASK_CODED(1'b1), .MASK_BYTE0(8'hFE),
    .MASK_BYTE1(8'h5A)) dut_mask (.clk_sys_i, .reset_n_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o(),
    .pready_o(), .pslverr_o(), .prog_mode_i, .prog_req_i,
    .prog_rdata_o(m_rdata), .prog_ack_o(), .prog_err_o(m_err),
    .cfg_o(m_cfg), .cfg_valid_o(), .prog_mem_read_allow_o(),
    .data_nvm_read_allow_o(), .prog_mem_erase_o());
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic we, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, we, a, d};
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    se = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask : apb
  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    pstrb_i = 4'hF;
    reset_n_i = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    tool.set_mode(1'b1);
    foreach (rows[i]) begin
      tool.access(1'b1, 1'b0, rows[i][25:18], rb, ok);
      tool.access(1'b1, 1'b1, rows[i][17:10], rb, ok);
      tool.access(1'b0, 1'b1, 8'h00, rb, ok);
      check(32'(rb), 32'(rows[i][17:10]));
      apb(1'b1, 8'h00, 32'h0000_0001);
      repeat (2) @(posedge clk_sys_i);
      check(32'(cfg_o), 32'(rows[i][9:0]));
      check(32'(prog_mem_read_allow_o), 32'(!rows[i][8]));
    end
    tool.set_mode(1'b0);
    tool.access(1'b1, 1'b1, 8'h00, rb, ok);
    check(32'(ok), 32'h0000_0000);
    tool.set_mode(1'b1);
    tool.access(1'b0, 1'b1, 8'h00, rb, ok);
    check(32'(rb), 32'h0000_0082);
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    check(32'(se), 32'h0000_0001);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check(32'(cfg_o), 32'(rows[7][9:0]));
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    check(32'(se), 32'h0000_0000);
    tool.access(1'b1, 1'b0, 8'hFE, rb, ok);
    check(32'(prog_mem_erase_o), 32'h0000_0001);
    check(32'(m_err), 32'h0000_0001);
    repeat (2) @(posedge clk_sys_i);
    check(32'(cfg_o), 32'h0000_006C);
    check(32'(prog_mem_read_allow_o), 32'h0000_0001);
    check(32'(data_nvm_read_allow_o), 32'h0000_0001);
    tool.access(1'b0, 1'b1, 8'h00, rb, ok);
    check(32'(rb), 32'h0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rd, 32'h0000_0007);
    apb(1'b1, 8'h00, 32'h0000_0002);
    apb(1'b0, 8'h04, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(32'(cfg_valid_o), 32'h0000_0000);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check(32'(cfg_o), 32'h0000_0383);
    tool.access(1'b0, 1'b0, 8'h00, rb, ok);
    check(32'(rb), 32'h0000_00FF);
    check(32'(m_rdata), 32'h0000_00FE);
    check(32'(m_cfg), 32'h0000_0226);
    results();
  end
  // A run of under two hundred cycles is expected; this cuts off a hang.
  initial begin
    #300_000;
    num_errors++;
    results();
  end
endmodule : testbench
